// >>> design/sent_tx.sv
/*
   Sensor-side transmitter of a single-edge nibble link: sync pulse, status
   nibble with two slow-channel bits, data nibbles, checksum, optional pause.
   Assumes all inputs come from logic on clk_sys; the line is push-pull.
*/
`timescale 1ns/1ps
module sent_tx
   import sent_pkg::*;
#(
   parameter int         NIBBLES   = 6,
   parameter logic [7:0] LOW_TICKS = 8'h05,
   parameter logic [3:0] CRC_POLY  = 4'hD,
   parameter logic [3:0] CRC_SEED  = 4'h5
) (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // fast data words
   input  wire logic                   in_valid,
   input  wire logic [4*NIBBLES-1:0]   in_data,
   output logic                        in_ready,
   // slow channel message
   input  wire logic                   slow_load,
   input  wire sent_pkg::slow_fmt_t    slow_fmt,
   input  wire logic [7:0]             slow_id,
   input  wire logic [15:0]            slow_data,
   input  wire logic [5:0]             slow_crc,
   output logic                        slow_ready,
   // configuration
   input  wire logic [11:0]            tick_div,
   input  wire logic [7:0]             pause_ticks,
   input  wire logic [1:0]             stat_lo,
   // link
   output logic                        tx_line,
   output logic                        msg_start
);
   import sent_pkg::*;
   localparam int DW = 4 * NIBBLES;

   typedef struct packed {
      frame_t      fr;
      logic [11:0] div;
      logic [11:0] pre;
      logic [7:0]  tcnt;
      logic [7:0]  len;
      logic [2:0]  idx;
      logic [3:0]  nib;
      logic [DW-1:0] word;
      logic [1:0]  lo;
      logic [7:0]  pause;
      logic [17:0] s3;
      logic [17:0] s2;
      logic [4:0]  slen;
      logic [4:0]  sidx;
      logic        pend;
      slow_fmt_t   pfmt;
      logic [7:0]  pid;
      logic [15:0] pdat;
      logic [5:0]  pcrc;
      logic        sready;
      logic        line;
      logic        mstart;
   } tx_t;

   tx_t q;
   tx_t d;
   logic          tick;
   logic          buf_pop;
   logic          buf_valid;
   logic [DW-1:0] buf_data;
   logic [40:0]   sb;
   logic [4:0]    spos;

   function automatic logic [11:0] clamp_div(input logic [11:0] v);
      return (v < DIV_MIN) ? DIV_MIN : ((v > DIV_MAX) ? DIV_MAX : v);
   endfunction

   function automatic logic [3:0] crc_calc(input logic [DW-1:0] w);
      logic [3:0] c;
      logic       fb;
      c = CRC_SEED;
      for (int i = DW - 1; i >= 0; i--) begin
         fb = c[3] ^ w[i];
         c  = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
      end
      return c;
   endfunction

   function automatic logic [3:0] nib_at(input logic [DW-1:0] w, input logic [2:0] i);
      return w[(NIBBLES - 1 - int'(i)) * 4 +: 4];
   endfunction

   // returns {length, bit-3 pattern, bit-2 pattern}, first message at bit 17
   function automatic logic [40:0] slow_build(input slow_fmt_t f, input logic [7:0] id,
                                              input logic [15:0] dat, input logic [5:0] crc);
      logic [17:0] b3;
      logic [17:0] b2;
      logic [4:0]  n;
      n  = SLOW_ENH_LEN;
      b2 = {crc, dat[11:0]};
      unique case (f)
         SLOW_ENH12: begin
            b3 = {ENH_START, 1'b0, 1'b0, id[7:4], 1'b0, id[3:0], 1'b0};
         end
         SLOW_ENH16: begin
            b3 = {ENH_START, 1'b0, 1'b1, id[3:0], 1'b0, dat[15:12], 1'b0};
         end
         default: begin
            n  = SLOW_SHORT_LEN;
            b3 = 18'h20000;
            b2 = {id[3:0], dat[7:0], crc[3:0], 2'b00};
         end
      endcase
      return {n, b3, b2};
   endfunction

   sent_buf #(
      .WIDTH (DW),
      .DEPTH (2)
   ) u_buf (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (in_valid),
      .in_data   (in_data),
      .in_ready  (in_ready),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (buf_pop)
   );

   always_comb begin
      d        = q;
      d.mstart = 1'b0;
      buf_pop  = 1'b0;
      sb       = slow_build(q.pfmt, q.pid, q.pdat, q.pcrc);
      spos     = SLOW_TOP - q.sidx;
      tick     = (q.pre == '0);
      d.pre    = tick ? 12'(q.div - 1'b1) : 12'(q.pre - 1'b1);
      if (tick) begin
         if (q.tcnt == 8'(q.len - 1'b1)) begin
            d.tcnt = '0;
            unique case (q.fr)
               FR_SYNC: begin
                  d.fr  = FR_STAT;
                  d.nib = {q.s3[spos], q.s2[spos], q.lo};
               end
               FR_STAT: begin
                  d.fr  = FR_DATA;
                  d.idx = '0;
                  d.nib = nib_at(q.word, 3'h0);
               end
               FR_DATA: begin
                  if (q.idx == 3'(NIBBLES - 1)) begin
                     d.fr  = FR_CRC;
                     d.nib = crc_calc(q.word);
                  end else begin
                     d.idx = 3'(q.idx + 1'b1);
                     d.nib = nib_at(q.word, 3'(q.idx + 1'b1));
                  end
               end
               FR_CRC: begin
                  if (q.pause != '0) begin
                     d.fr = FR_PAUSE;
                  end else begin
                     d.fr = FR_SYNC;
                  end
               end
               FR_PAUSE: begin
                  d.fr = FR_SYNC;
               end
            endcase
            d.len = NIB_BASE + {4'h0, d.nib};
            if (d.fr == FR_PAUSE) begin
               d.len = q.pause;
            end
            // a new message starts on its own, whether or not fresh data arrived
            if (d.fr == FR_SYNC) begin
               d.len    = SYNC_TICKS;
               d.div    = clamp_div(tick_div);
               d.pre    = 12'(d.div - 1'b1);
               d.lo     = stat_lo;
               d.pause  = pause_ticks;
               d.mstart = 1'b1;
               buf_pop  = buf_valid;
               if (buf_valid) begin
                  d.word = buf_data;
               end
               if (q.sidx == 5'(q.slen - 1'b1)) begin
                  d.sidx = '0;
                  if (q.pend) begin
                     d.slen = sb[40:36];
                     d.s3   = sb[35:18];
                     d.s2   = sb[17:0];
                     d.pend = 1'b0;
                  end
               end else begin
                  d.sidx = 5'(q.sidx + 1'b1);
               end
            end
         end else begin
            d.tcnt = 8'(q.tcnt + 1'b1);
         end
      end
      if (slow_load && !q.pend) begin
         d.pend = 1'b1;
         d.pfmt = slow_fmt;
         d.pid  = slow_id;
         d.pdat = slow_data;
         d.pcrc = slow_crc;
      end
      d.sready = !d.pend;
      d.line   = (d.tcnt >= LOW_TICKS);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q        <= '0;
         q.fr     <= FR_PAUSE;
         q.len    <= 8'h01;
         q.div    <= DIV_RESET;
         q.slen   <= SLOW_SHORT_LEN;
         q.sidx   <= 5'(SLOW_SHORT_LEN - 1'b1);
         q.pfmt   <= SLOW_SHORT;
         q.sready <= 1'b1;
         q.line   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign tx_line    = q.line;
   assign msg_start  = q.mstart;
   assign slow_ready = q.sready;

   // cycles since the last message start, read only by the checks below
   logic [15:0] gap_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gap_q <= 16'h0000;
      end else begin
         gap_q <= d.mstart ? 16'h0001 : 16'(gap_q + 1'b1);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence sync_done_s;
      (q.fr == FR_SYNC) ##1 (q.fr != FR_SYNC);
   endsequence

   sequence data_last_s;
      (q.fr == FR_DATA) && (q.idx == 3'(NIBBLES - 1)) ##1 (q.fr != FR_DATA);
   endsequence

   tick_range_a: assert property (q.div >= DIV_MIN && q.div <= DIV_MAX)
      else $error("tick divider outside allowed range");
   div_hold_a: assert property ($changed(q.div) |-> q.mstart)
      else $error("tick divider changed inside a message");
   sync_len_a: assert property (q.mstart |-> q.fr == FR_SYNC && q.len == SYNC_TICKS)
      else $error("message did not open with a 56-tick sync");
   nib_len_a: assert property (q.fr inside {FR_STAT, FR_DATA, FR_CRC}
                               |-> q.len == NIB_BASE + {4'h0, q.nib})
      else $error("nibble period not twelve plus value");
   after_sync_a: assert property (sync_done_s |-> q.fr == FR_STAT)
      else $error("status nibble did not follow sync");
   after_data_a: assert property (data_last_s |-> q.fr == FR_CRC)
      else $error("checksum did not follow the last data nibble");
   crc_nib_a: assert property (q.fr == FR_CRC |-> q.nib == crc_calc(q.word))
      else $error("checksum nibble does not match data");
   slow_bits_a: assert property (q.fr == FR_STAT |->
                                 q.nib[3:2] == {q.s3[SLOW_TOP - q.sidx], q.s2[SLOW_TOP - q.sidx]})
      else $error("status nibble slow bits wrong");
   fall_start_a: assert property ($fell(q.line) |-> q.tcnt == 8'h00 && $past(tick))
      else $error("falling edge not at period start");
   msg_time_a: assert property (q.div == DIV_MIN && q.pause == 8'h00 && NIBBLES <= 6
                                |-> gap_q < 16'(MSG_MAX_CYC))
      else $error("message longer than 1 ms at shortest tick");
endmodule

// >>> design/sent_pkg.sv
/*
   Shared constants and types of the single-wire nibble transmitter.
   Assumes a 40 MHz system clock; all cycle counts are derived from it here.
*/
package sent_pkg;
   // clock and tick range
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_MIN_NS   = 3000;
   localparam int unsigned TICK_MAX_NS   = 90000;
   localparam int unsigned MSG_MAX_NS    = 1000000;
   // least tick rounds up, longest tick rounds down
   localparam logic [11:0] DIV_MIN     = 12'((TICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] DIV_MAX     = 12'(TICK_MAX_NS / CLK_PERIOD_NS);
   localparam logic [11:0] DIV_RESET   = DIV_MIN;
   localparam int unsigned MSG_MAX_CYC = MSG_MAX_NS / CLK_PERIOD_NS;
   // frame lengths in ticks
   localparam logic [7:0]  SYNC_TICKS  = 8'h38;
   localparam logic [7:0]  NIB_BASE    = 8'h0C;
   // slow channel
   localparam logic [4:0]  SLOW_SHORT_LEN = 5'h10;
   localparam logic [4:0]  SLOW_ENH_LEN   = 5'h12;
   localparam logic [5:0]  ENH_START      = 6'h3F;
   localparam logic [4:0]  SLOW_TOP       = 5'h11;

   typedef enum logic [1:0] {SLOW_SHORT, SLOW_ENH12, SLOW_ENH16} slow_fmt_t;
   typedef enum logic [2:0] {FR_SYNC, FR_STAT, FR_DATA, FR_CRC, FR_PAUSE} frame_t;
endpackage

// >>> design/sent_buf.sv
/*
   Small FIFO with valid/ready on both sides; entries are registers.
   Assumes producer and consumer run on the same clock as the FIFO.
*/
`timescale 1ns/1ps
module sent_buf #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               cnt;
      logic                        rdy;
   } buf_t;

   buf_t q;
   buf_t d;
   logic push;
   logic pop;

   always_comb begin
      d    = q;
      push = in_valid && q.rdy;
      pop  = out_ready && (q.cnt != '0);
      if (push) begin
         d.mem[q.wr] = in_data;
         d.wr        = (q.wr == PW'(DEPTH - 1)) ? '0 : PW'(q.wr + 1'b1);
      end
      if (pop) begin
         d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : PW'(q.rd + 1'b1);
      end
      d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
      // ready is registered so the fill side sees a flop, at the cost of no pass-through
      d.rdy = (d.cnt != CW'(DEPTH));
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q     <= '0;
         q.rdy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_ready  = q.rdy;
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rd];
endmodule

// >>> bench/sent_rx_model.sv
/*
   Receiver-side model of the single-wire nibble link: measures each
   falling-to-falling period and the low time inside it, in clk_sys cycles.
   Assumes the line is push-pull and sampled on the same clock as the sender.
*/
`timescale 1ns/1ps
module sent_rx_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // link, listen only
   input  wire logic        tx_line,
   // measurements
   output logic             per_valid,
   output logic [15:0]      per_cyc,
   output logic [15:0]      low_cyc
);
   logic        line_q;
   logic [15:0] cnt_q;
   logic [15:0] low_q;

   // counts in system cycles, so the tick is only known relative to the divider
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         line_q    <= 1'b1;
         cnt_q     <= 16'h0000;
         low_q     <= 16'h0000;
         per_valid <= 1'b0;
         per_cyc   <= 16'h0000;
         low_cyc   <= 16'h0000;
      end else begin
         line_q    <= tx_line;
         per_valid <= 1'b0;
         if (line_q && !tx_line) begin
            per_valid <= 1'b1;
            per_cyc   <= cnt_q;
            low_cyc   <= low_q;
            cnt_q     <= 16'h0001;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
         if (!line_q && tx_line) begin
            low_q <= cnt_q;
         end
      end
   end
endmodule

// >>> bench/testbench.sv
/*
   Self-checking bench of the nibble transmitter: buffer, slow-channel
   handshake, frame periods, checksum, divider timing and pause.
   Assumes the design package and the receiver model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   import sent_pkg::*;
   localparam int          LOW    = 5;
   localparam logic [23:0] WORD_A = 24'hF0A5C3;
   localparam logic [23:0] WORD_B = 24'h102030;
   logic        clk_sys, rst, in_valid, in_ready, slow_load, slow_ready;
   logic        tx_line, msg_start, per_valid;
   logic [23:0] in_data;
   slow_fmt_t   slow_fmt;
   logic [7:0]  slow_id, pause_ticks;
   logic [15:0] slow_data, per_cyc, low_cyc;
   logic [5:0]  slow_crc;
   logic [11:0] tick_div;
   logic [1:0]  stat_lo;
   int          err_total, n_checks;

   sent_tx #(.NIBBLES(6), .LOW_TICKS(8'h05), .CRC_POLY(4'hD), .CRC_SEED(4'h5)) dut (
      .clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_data(in_data),
      .in_ready(in_ready), .slow_load(slow_load), .slow_fmt(slow_fmt), .slow_id(slow_id),
      .slow_data(slow_data), .slow_crc(slow_crc), .slow_ready(slow_ready),
      .tick_div(tick_div), .pause_ticks(pause_ticks), .stat_lo(stat_lo),
      .tx_line(tx_line), .msg_start(msg_start));
   sent_rx_model rx (.clk_sys(clk_sys), .rst(rst), .tx_line(tx_line),
      .per_valid(per_valid), .per_cyc(per_cyc), .low_cyc(low_cyc));

   always #12.5 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // longest frame used is the 56-tick sync at 160 cycles, far inside this bound
   task automatic next_per;
      for (int k = 0; k < 40000; k++) begin
         @(posedge clk_sys);
         #1;
         if (per_valid === 1'b1) return;
      end
      chk(32'h0, 32'h1);
      stop_test;
   endtask

   task automatic test_fifo;
      @(posedge clk_sys);
      in_valid <= 1'b1;
      in_data  <= WORD_A;
      @(posedge clk_sys);
      in_data <= WORD_B;
      @(posedge clk_sys);
      in_valid <= 1'b0;
      #1 chk({31'h0, in_ready}, 32'h0);
      $display("test fifo done");
   endtask

   task automatic test_slow;
      #1 chk({31'h0, slow_ready}, 32'h1);
      @(posedge clk_sys);
      slow_load <= 1'b1;
      @(posedge clk_sys);
      slow_load <= 1'b0;
      #1 chk({31'h0, slow_ready}, 32'h0);
      $display("test slow done");
   endtask

   task automatic sync_up;
      int k;
      for (k = 0; k < 400; k++) begin
         @(posedge clk_sys);
         #1;
         if (msg_start === 1'b1) break;
      end
      chk(32'(k < 400), 32'h1);
      // the fall that opens the first sync closes no real period
      if (k < 400) begin
         next_per;
      end else begin
         stop_test;
      end
   endtask

   task automatic run_msg(input string name, input int div, input logic [23:0] w,
                          input logic [1:0] st, input logic [7:0] pz,
                          input logic [11:0] ndiv, input logic [1:0] nst, input logic [7:0] npz);
      int         t[10];
      int         sum;
      int         n;
      logic [3:0] c;
      c = 4'h5;
      for (int i = 23; i >= 0; i--) begin
         c = (c[3] ^ w[i]) ? ({c[2:0], 1'b0} ^ 4'hD) : {c[2:0], 1'b0};
      end
      // sync, status, six data nibbles first nibble on top, checksum, pause
      t[0] = 56;
      t[1] = 12 + int'(st);
      for (int i = 5; i >= 0; i--) begin
         t[7 - i] = 12 + int'(w[4*i +: 4]);
      end
      t[8] = 12 + int'(c);
      t[9] = int'(pz);
      n    = (pz != 8'h00) ? 10 : 9;
      sum  = 0;
      for (int j = 0; j < n; j++) begin
         next_per;
         sum += int'(per_cyc);
         if (j == 0) begin
            chk(32'(per_cyc), 32'(t[j] * div));
         end else if (j == 8) begin
            chk(32'(per_cyc), 32'(t[j] * div));
         end else if (j == 9) begin
            chk(32'(per_cyc), 32'(t[j] * div));
         end else begin
            chk(32'(per_cyc), 32'(t[j] * div));
         end
         chk(32'(low_cyc), 32'(LOW * div));
         if (j == 0) begin
            @(posedge clk_sys);
            tick_div    <= ndiv;
            stat_lo     <= nst;
            pause_ticks <= npz;
         end
      end
      if (div == 120) chk(32'(sum < int'(MSG_MAX_CYC)), 32'h1);
      $display("test %s done", name);
   endtask

   initial begin
      clk_sys     = 1'b0;
      rst         = 1'b1;
      in_valid    = 1'b0;
      in_data     = 24'h000000;
      slow_load   = 1'b0;
      slow_fmt    = SLOW_ENH12;
      slow_id     = 8'h5A;
      slow_data   = 16'h0ABC;
      slow_crc    = 6'h15;
      tick_div    = 12'h078;
      pause_ticks = 8'h00;
      stat_lo     = 2'h1;
      err_total   = 0;
      n_checks    = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      // the first message starts on the first edge after reset, before any word is queued
      sync_up;
      test_fifo;
      test_slow;
      // empty buffer at the first start sends the reset word; a new divider set inside
      // a message must wait for the next one
      run_msg("first", 120, 24'h000000, 2'h1, 8'h00, 12'h0A0, 2'h3, 8'h00);
      chk({31'h0, in_ready}, 32'h1);
      run_msg("second", 160, WORD_A, 2'h3, 8'h00, 12'h005, 2'h0, 8'h0C);
      // divider below range clamps to the shortest tick
      run_msg("third", 120, WORD_B, 2'h0, 8'h0C, 12'h078, 2'h0, 8'h00);
      stop_test;
   end
endmodule
